// [include/gpp_pkg.sv]
// gpio port package: register map, reset values, mode codes
// assumes a single 250 MHz system clock and an apb register slave
package gpp_pkg;
  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [3:0] IDX_PA_DATA    = 4'h0;
  localparam logic [3:0] IDX_PA_DIR     = 4'h1;
  localparam logic [3:0] IDX_PA_OPT     = 4'h2;
  localparam logic [3:0] IDX_PB_DATA    = 4'h3;
  localparam logic [3:0] IDX_PB_DIR     = 4'h4;
  localparam logic [3:0] IDX_PB_OPT     = 4'h5;
  localparam logic [3:0] IDX_EI_CTRL    = 4'h6;
  localparam logic [3:0] IDX_EI_PEND    = 4'h7;
  localparam logic [11:0] ADDR_STRIDE   = 12'h004;
  // ==========================================================
  // widths and reset values
  localparam int          PA_W          = 8;
  localparam int          PB_W          = 7;
  localparam logic [7:0]  RST_PA_DATA   = 8'hFF;
  localparam logic [7:0]  RST_PA_DIR    = 8'h00;
  localparam logic [7:0]  RST_PA_OPT    = 8'h40;
  localparam logic [6:0]  RST_PB_DATA   = 7'h7F;
  localparam logic [6:0]  RST_PB_DIR    = 7'h00;
  localparam logic [6:0]  RST_PB_OPT    = 7'h00;
  // ==========================================================
  // external interrupt control fields (one edge bit per port)
  localparam int          EI_PA_RISE_BIT = 0;
  localparam int          EI_PB_RISE_BIT = 1;
  // pin configuration decoded from {direction, option}
  typedef enum logic [1:0] {
    GPP_IN_FLOAT, GPP_IN_PULLUP, GPP_OUT_OD, GPP_OUT_PP
  } gpp_mode_e;
endpackage : gpp_pkg

// [include/gpp_pin_if.sv]
// pin bundle between the port top and its per-port pin logic
// assumes one port of up to eight pins
`timescale 1ns/1ps
`default_nettype none
interface gpp_pin_if #(parameter int W = 8);
  logic [W-1:0] data;       // data latch
  logic [W-1:0] dir;        // direction bits
  logic [W-1:0] opt;        // option bits
  logic [W-1:0] af_oe;      // peripheral output enable
  logic [W-1:0] af_out;     // peripheral output value
  logic [W-1:0] pin_sync;   // synchronised pad level
  logic [W-1:0] pad_out;
  logic [W-1:0] pad_oe;
  logic [W-1:0] pull_en;
  logic [W-1:0] rd_val;     // value seen by a data read
  logic [W-1:0] af_in;      // value to peripheral input
  logic [W-1:0] irq_cfg;    // pin selected as interrupt input
  modport ctl (output data, dir, opt, af_oe, af_out, pin_sync,
               input pad_out, pad_oe, pull_en, rd_val, af_in, irq_cfg);
  modport pin (input data, dir, opt, af_oe, af_out, pin_sync,
               output pad_out, pad_oe, pull_en, rd_val, af_in, irq_cfg);
endinterface : gpp_pin_if
`default_nettype wire

// [src/gpp_pin_logic.sv]
// per-port combinational pin steering, one slice per pin
// assumes synchronised pad levels and registered controls
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_logic (
  // pin bundle
  gpp_pin_if.pin p
);
  // decode direction and option into a pin mode
  function automatic gpp_pkg::gpp_mode_e mode_of(input logic d, input logic o);
    mode_of = gpp_pkg::gpp_mode_e'({d, o});
  endfunction : mode_of

  // ==========================================================
  // per pin slice
  genvar i;
  generate
    for (i = 0; i < $bits(p.data); i++) begin : g_pin
      gpp_pkg::gpp_mode_e m;
      assign m = mode_of(p.dir[i], p.opt[i]);                  // [RL14] [RL15]
      // peripheral output overrides port settings
      always_comb begin
        if (p.af_oe[i]) begin                                  // [RL3]
          p.pad_oe[i]  = 1'b1;
          p.pad_out[i] = p.af_out[i];
        end else if (m == gpp_pkg::GPP_OUT_PP) begin           // [RL2]
          p.pad_oe[i]  = 1'b1;
          p.pad_out[i] = p.data[i];
        end else if (m == gpp_pkg::GPP_OUT_OD) begin           // [RL2]
          p.pad_oe[i]  = ~p.data[i];  // a one leaves the pin floating
          p.pad_out[i] = 1'b0;
        end else begin
          p.pad_oe[i]  = 1'b0;
          p.pad_out[i] = 1'b0;
        end
      end
      // pull-up only in pull-up input without override
      assign p.pull_en[i] = ~p.af_oe[i] & (m == gpp_pkg::GPP_IN_PULLUP);
      // read: latch in output, pin when overriding an output, af value when overriding an input, else pin
      assign p.rd_val[i]  = p.af_oe[i] ? (p.dir[i] ? p.pin_sync[i] : p.af_out[i]) // [RL3] [RL4]
                          : (p.dir[i] ? p.data[i] : p.pin_sync[i]);          // [RL1] [RL16]
      // peripheral input: latch when output, pin level otherwise
      assign p.af_in[i]   = p.dir[i] ? p.data[i] : p.pin_sync[i];            // [RL5] [RL6]
      assign p.irq_cfg[i] = (m == gpp_pkg::GPP_IN_PULLUP);                  // [RL13]
    end
  endgenerate
endmodule : gpp_pin_logic
`default_nettype wire

// [src/gpp_port.sv]
// gpio ports a (8 pins) and b (7 pins) with apb registers and
// external interrupt request latches
// assumes synchronous apb master on CLK_SYS; pads resolved outside
//
// Function
// [RL1] output mode drives latch; read returns latch
// [RL2] zero drives low; one floats in open-drain
// [RL3] peripheral output overrides port pin settings
// [RL4] input plus peripheral output reads peripheral
// [RL5] output pin feeds latch to peripheral
// [RL6] floating input passes pin to peripheral
// [RL7] software disables interrupt before peripheral input
// [RL8] bidirectional peripheral pins use floating input
// [RL9] never mix analog and digital functions
// [RL10] converter inputs use floating input
// [RL11] software follows safe configuration transitions
// [RL12] low-power modes keep pins; interrupts wake
// [RL13] interrupt needs interrupt mode and unmasked
// [RL14] direction,option decode into four modes
// [RL15] bit index selects same pin
// [RL16] input mode reads live pin level
// [RL17] vector fetch or edge change clears pending
// [RL18] port a eight pins, port b seven
`timescale 1ns/1ps
`default_nettype none
module gpp_port (
  // clock and reset
  input  wire  logic        CLK_SYS,
  input  wire  logic        RSTN,
  // apb slave
  input  wire  logic        PSEL,
  input  wire  logic        PENABLE,
  input  wire  logic        PWRITE,
  input  wire  logic [11:0] PADDR,
  input  wire  logic [31:0] PWDATA,
  output logic              PREADY,
  output logic [31:0]       PRDATA,
  output logic              PSLVERR,
  // port a pads
  input  wire  logic [7:0]  PA_IN,
  output logic [7:0]        PA_OUT,
  output logic [7:0]        PA_OE,
  output logic [7:0]        PA_PULL,
  // port b pads
  input  wire  logic [6:0]  PB_IN,
  output logic [6:0]        PB_OUT,
  output logic [6:0]        PB_OE,
  output logic [6:0]        PB_PULL,
  // peripheral alternate functions
  input  wire  logic [7:0]  PA_AF_OE,
  input  wire  logic [7:0]  PA_AF_OUT,
  output logic [7:0]        PA_AF_IN,
  input  wire  logic [6:0]  PB_AF_OE,
  input  wire  logic [6:0]  PB_AF_OUT,
  output logic [6:0]        PB_AF_IN,
  // processor side
  input  wire  logic        IMASK,
  input  wire  logic        PA_VEC_ACK,
  input  wire  logic        PB_VEC_ACK,
  output logic              PA_IRQ,
  output logic              PB_IRQ,
  output logic              WAKE
);
  // ==========================================================
  // state
  logic [7:0] pa_data_reg, pa_dir_reg, pa_opt_reg;
  logic [6:0] pb_data_reg, pb_dir_reg, pb_opt_reg;
  logic [1:0] ei_ctrl_reg;
  logic [1:0] pend_reg, pend_next;
  logic [7:0] pa_s1_reg, pa_s2_reg, pa_prev_reg;
  logic [6:0] pb_s1_reg, pb_s2_reg, pb_prev_reg;
  logic       wr_en, rd_en, hit;
  logic [3:0] idx;
  logic [31:0] rd_mux;
  logic [1:0] edge_hit;

  gpp_pin_if #(.W(gpp_pkg::PA_W)) pa_if ();
  gpp_pin_if #(.W(gpp_pkg::PB_W)) pb_if ();

  // ==========================================================
  // two-stage pad synchronisers; only stage two is read
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pa_s1_reg <= 8'h00;
      pa_s2_reg <= 8'h00;
      pb_s1_reg <= 7'h00;
      pb_s2_reg <= 7'h00;
    end else begin
      pa_s1_reg <= PA_IN;
      pa_s2_reg <= pa_s1_reg;
      pb_s1_reg <= PB_IN;
      pb_s2_reg <= pb_s1_reg;
    end
  end

  // pin slices, one instance per port
  assign pa_if.data = pa_data_reg;
  assign pa_if.dir = pa_dir_reg;
  assign pa_if.opt = pa_opt_reg;
  assign pa_if.af_oe = PA_AF_OE;
  assign pa_if.af_out = PA_AF_OUT;
  assign pa_if.pin_sync = pa_s2_reg;
  assign pb_if.data = pb_data_reg;
  assign pb_if.dir = pb_dir_reg;
  assign pb_if.opt = pb_opt_reg;
  assign pb_if.af_oe = PB_AF_OE;
  assign pb_if.af_out = PB_AF_OUT;
  assign pb_if.pin_sync = pb_s2_reg;
  gpp_pin_logic u_pa (.p(pa_if.pin));                          // [RL18]
  gpp_pin_logic u_pb (.p(pb_if.pin));                          // [RL18]

  // ==========================================================
  // apb decode: zero wait state, unmapped or misaligned gives error
  assign idx   = PADDR[5:2];
  assign hit   = (PADDR[1:0] == 2'b00) && (PADDR[11:2] <= 10'(gpp_pkg::IDX_EI_PEND));
  assign wr_en = PSEL & PENABLE & PWRITE & hit;
  assign rd_en = PSEL & ~PENABLE & ~PWRITE;

  // configuration and data latches; writes never touch input pins
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pa_data_reg <= gpp_pkg::RST_PA_DATA;
      pa_dir_reg  <= gpp_pkg::RST_PA_DIR;
      pa_opt_reg  <= gpp_pkg::RST_PA_OPT;
      pb_data_reg <= gpp_pkg::RST_PB_DATA;
      pb_dir_reg  <= gpp_pkg::RST_PB_DIR;
      pb_opt_reg  <= gpp_pkg::RST_PB_OPT;
      ei_ctrl_reg <= 2'b00;
    end else if (wr_en) begin
      case (idx)
        gpp_pkg::IDX_PA_DATA: pa_data_reg <= PWDATA[7:0];      // [RL1]
        gpp_pkg::IDX_PA_DIR:  pa_dir_reg  <= PWDATA[7:0];
        gpp_pkg::IDX_PA_OPT:  pa_opt_reg  <= PWDATA[7:0];
        gpp_pkg::IDX_PB_DATA: pb_data_reg <= PWDATA[6:0];
        gpp_pkg::IDX_PB_DIR:  pb_dir_reg  <= PWDATA[6:0];
        gpp_pkg::IDX_PB_OPT:  pb_opt_reg  <= PWDATA[6:0];
        gpp_pkg::IDX_EI_CTRL: ei_ctrl_reg <= PWDATA[1:0];
        default: ;
      endcase
    end
  end

  // read mux, captured in setup so PRDATA is a flop in access
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      gpp_pkg::IDX_PA_DATA: rd_mux = {24'h000000, pa_if.rd_val};     // [RL1] [RL16]
      gpp_pkg::IDX_PA_DIR:  rd_mux = {24'h000000, pa_dir_reg};
      gpp_pkg::IDX_PA_OPT:  rd_mux = {24'h000000, pa_opt_reg};
      gpp_pkg::IDX_PB_DATA: rd_mux = {25'h0000000, pb_if.rd_val};
      gpp_pkg::IDX_PB_DIR:  rd_mux = {25'h0000000, pb_dir_reg};
      gpp_pkg::IDX_PB_OPT:  rd_mux = {25'h0000000, pb_opt_reg};
      gpp_pkg::IDX_EI_CTRL: rd_mux = {30'h00000000, ei_ctrl_reg};
      gpp_pkg::IDX_EI_PEND: rd_mux = {30'h00000000, pend_reg};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      PREADY  <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;   // answer in the first access cycle
      PSLVERR <= PSEL & ~PENABLE & ~hit;
      if (rd_en) begin
        PRDATA <= hit ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // external interrupt request latches, one per port vector
  always_comb begin
    edge_hit[0] = |(pa_if.irq_cfg & (ei_ctrl_reg[gpp_pkg::EI_PA_RISE_BIT] ?
                   (pa_s2_reg & ~pa_prev_reg) : (~pa_s2_reg & pa_prev_reg)));
    edge_hit[1] = |(pb_if.irq_cfg & (ei_ctrl_reg[gpp_pkg::EI_PB_RISE_BIT] ?
                   (pb_s2_reg & ~pb_prev_reg) : (~pb_s2_reg & pb_prev_reg)));
    pend_next = pend_reg;
    if (PA_VEC_ACK) pend_next[0] = 1'b0;                       // [RL17]
    if (PB_VEC_ACK) pend_next[1] = 1'b0;                       // [RL17]
    if (wr_en && idx == gpp_pkg::IDX_EI_CTRL) pend_next = 2'b00; // [RL17]
    pend_next = pend_next | edge_hit;  // a new edge beats the clear
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pend_reg    <= 2'b00;
      pa_prev_reg <= 8'h00;
      pb_prev_reg <= 7'h00;
    end else begin
      pend_reg    <= pend_next;
      pa_prev_reg <= pa_s2_reg;
      pb_prev_reg <= pb_s2_reg;
    end
  end

  // requests gated by the global mask; wake is also masked and registered on CLK_SYS
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      PA_IRQ <= 1'b0;
      PB_IRQ <= 1'b0;
      WAKE   <= 1'b0;
    end else begin
      PA_IRQ <= pend_next[0] & ~IMASK;                         // [RL13]
      PB_IRQ <= pend_next[1] & ~IMASK;                         // [RL13]
      WAKE   <= |(pend_next & {2{~IMASK}});                    // [RL12]
    end
  end

  // ==========================================================
  // pad and peripheral outputs registered; no low-power gating [RL12]
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      PA_OUT <= 8'h00;
      PA_OE <= 8'h00;
      PA_PULL <= 8'h00;
      PB_OUT <= 7'h00;
      PB_OE <= 7'h00;
      PB_PULL <= 7'h00;
      PA_AF_IN <= 8'h00;
      PB_AF_IN <= 7'h00;
    end else begin
      PA_OUT <= pa_if.pad_out;                                 // [RL2] [RL3]
      PA_OE <= pa_if.pad_oe;
      PA_PULL <= pa_if.pull_en;
      PB_OUT <= pb_if.pad_out;
      PB_OE <= pb_if.pad_oe;
      PB_PULL <= pb_if.pull_en;
      PA_AF_IN <= pa_if.af_in;                                 // [RL5] [RL6]
      PB_AF_IN <= pb_if.af_in;
    end
  end

  // ==========================================================
  // checks
  property p_pp_drive;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (!PA_AF_OE[0] && pa_dir_reg[0] && pa_opt_reg[0]) |=> (PA_OE[0] && PA_OUT[0] == $past(pa_data_reg[0]));
  endproperty
  a_pp_drive: assert property (p_pp_drive) else $error("push-pull pin not driven"); // [RL2]
  property p_od_float;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (!PA_AF_OE[1] && pa_dir_reg[1] && !pa_opt_reg[1] && pa_data_reg[1]) |=> !PA_OE[1];
  endproperty
  a_od_float: assert property (p_od_float) else $error("open-drain one driven"); // [RL2]
  property p_af_over;
    @(posedge CLK_SYS) disable iff (!RSTN)
      PB_AF_OE[2] |=> (PB_OE[2] && PB_OUT[2] == $past(PB_AF_OUT[2]));
  endproperty
  a_af_over: assert property (p_af_over) else $error("peripheral override lost"); // [RL3]
  property p_af_in;
    @(posedge CLK_SYS) disable iff (!RSTN)
      pa_dir_reg[3] |=> PA_AF_IN[3] == $past(pa_data_reg[3]);
  endproperty
  a_af_in: assert property (p_af_in) else $error("peripheral input not latch"); // [RL5]
  property p_mask;
    @(posedge CLK_SYS) disable iff (!RSTN)
      IMASK |=> !PA_IRQ && !PB_IRQ;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked"); // [RL13]
  property p_ack;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (PA_VEC_ACK && !edge_hit[0]) |=> !pend_reg[0];
  endproperty
  a_ack: assert property (p_ack) else $error("pending not cleared"); // [RL17]
  property p_wake;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (PA_IRQ || PB_IRQ) |-> WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on irq"); // [RL12]
  property p_rd_out;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (rd_en && hit && idx == gpp_pkg::IDX_PA_DATA && pa_dir_reg == 8'hFF && PA_AF_OE == 8'h00)
        |=> PRDATA[7:0] == $past(pa_data_reg);
  endproperty
  a_rd_out: assert property (p_rd_out) else $error("data read not latch"); // [RL1]
  property p_pull;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (!pb_dir_reg[0] && pb_opt_reg[0] && !PB_AF_OE[0]) |=> (PB_PULL[0] && !PB_OE[0]);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up mode wrong"); // [RL14]
  c_irq:   cover property (@(posedge CLK_SYS) disable iff (!RSTN) PA_IRQ ##1 PA_VEC_ACK);
  c_od:    cover property (@(posedge CLK_SYS) disable iff (!RSTN) PA_OE[1] ##1 !PA_OE[1]);
  c_af:    cover property (@(posedge CLK_SYS) disable iff (!RSTN) PB_AF_OE[2] && !pb_dir_reg[2]);
endmodule : gpp_port
`default_nettype wire

// [bench/gpp_pad_model.sv]
// pad model for the port: resolves every pad from port drive, pull-up and an external driver
// assumes the bench sets the external driver just after CLK_SYS edges
`timescale 1ns/1ps
`default_nettype none
module gpp_pad_model #(
  parameter int W = 15
) (
  // clock
  input  wire logic         clk,
  // port side
  input  wire logic [W-1:0] pad_out,
  input  wire logic [W-1:0] pad_oe,
  input  wire logic [W-1:0] pull,
  // external driver
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  // resolved pad level
  output logic      [W-1:0] pin
);
  // ==========================================================
  // undriven pads flip every cycle so a stale level never passes for a real one
  logic [W-1:0] float_reg = '0;
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end
  // ==========================================================
  // port drive first; the outside only drives pads the port leaves free
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pad_oe[i]) begin
        pin[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pin[i] = ext_val[i];
      end else if (pull[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = float_reg[i];
      end
    end
  end
endmodule : gpp_pad_model
`default_nettype wire

// [bench/gpp_port_tb.sv]
// self-checking bench for the gpio port: apb tasks, pad model, alternate functions, interrupts
// assumes the pad model resolves pins; no random stimulus
`timescale 1ns/1ps
`default_nettype none
module gpp_port_tb;
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic        imask, pa_ack, pb_ack, pa_irq, pb_irq, wake;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  pa_out, pa_oe, pa_pull, pa_af_oe, pa_af_out, pa_af_in, pa_pin;
  logic [6:0]  pb_out, pb_oe, pb_pull, pb_af_in, pb_pin, pb_af_oe, pb_af_out;
  logic [14:0] ext_val, ext_en;
  int          failures, checked;
  // ==========================================================
  // design and pads
  gpp_port gpp_port_inst (.CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .PA_IN(pa_pin), .PA_OUT(pa_out), .PA_OE(pa_oe), .PA_PULL(pa_pull),
    .PB_IN(pb_pin), .PB_OUT(pb_out), .PB_OE(pb_oe), .PB_PULL(pb_pull), .PA_AF_OE(pa_af_oe),
    .PA_AF_OUT(pa_af_out), .PA_AF_IN(pa_af_in), .PB_AF_OE(pb_af_oe), .PB_AF_OUT(pb_af_out),
    .PB_AF_IN(pb_af_in), .IMASK(imask), .PA_VEC_ACK(pa_ack), .PB_VEC_ACK(pb_ack),
    .PA_IRQ(pa_irq), .PB_IRQ(pb_irq), .WAKE(wake));
  gpp_pad_model #(.W(15)) gpp_pad_model_inst (.clk(clk_sys), .pad_out({pb_out, pa_out}),
    .pad_oe({pb_oe, pa_oe}), .pull({pb_pull, pa_pull}), .ext_val(ext_val), .ext_en(ext_en),
    .pin({pb_pin, pa_pin}));
  // ==========================================================
  // clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {6'h00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      failures++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, {24'h000000, d}, r, e);
  endtask : wr
  task automatic rdc(input string name, input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h00000000, r, e);
    chk(name, r, exp);
  endtask : rdc
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic        e;
    {rstn, psel, penable, pwrite, imask, pa_ack, pb_ack} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {pa_af_oe, pa_af_out} = 16'h0000;
    {pb_af_oe, pb_af_out} = 14'h0000;
    {ext_val, ext_en} = 30'h00000000;
    failures = 0;
    checked = 0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    // reset values and an unmapped address
    rdc("pa_dir", gpp_pkg::IDX_PA_DIR, 32'h00000000);
    rdc("pa_opt", gpp_pkg::IDX_PA_OPT, 32'h00000040);
    rdc("pb_opt", gpp_pkg::IDX_PB_OPT, 32'h00000000);
    chk("pa_pull", {24'h0, pa_pull}, 32'h00000040);
    apb(1'b0, 4'h8, 32'h0, r, e);
    chk("unmapped err", {31'h0, e}, 32'h00000001);
    chk("unmapped data", r, 32'h00000000);
    // output mode shows the reset latch: pin 6 push-pull, the rest open-drain
    wr(gpp_pkg::IDX_PA_DIR, 8'hFF);
    rdc("pa_data", gpp_pkg::IDX_PA_DATA, 32'h000000FF);
    chk("pa_oe od", {24'h0, pa_oe}, 32'h00000040);
    // push-pull against a conflicting outside level
    ext_en <= 15'h00FF;
    ext_val <= 15'h00A5;
    wr(gpp_pkg::IDX_PA_OPT, 8'hFF);
    wr(gpp_pkg::IDX_PA_DATA, 8'h5A);
    cyc(2);
    chk("pa_oe pp", {24'h0, pa_oe}, 32'h000000FF);
    chk("pa_out pp", {24'h0, pa_out}, 32'h0000005A);
    // open-drain: ones float, peripheral input sees the latch
    ext_en <= 15'h0000;
    wr(gpp_pkg::IDX_PA_OPT, 8'h00);
    wr(gpp_pkg::IDX_PA_DATA, 8'h96);
    cyc(4);
    chk("pa_oe od", {24'h0, pa_oe}, 32'h00000069);
    chk("pa_out od", {24'h0, pa_out & pa_oe}, 32'h00000000);
    chk("pa_af_in out", {24'h0, pa_af_in}, 32'h00000096);
    rdc("pa_data od", gpp_pkg::IDX_PA_DATA, 32'h00000096);
    // floating input reads the live pads
    ext_en <= 15'h00FF;
    ext_val <= 15'h003C;
    wr(gpp_pkg::IDX_PA_DIR, 8'h00);
    cyc(4);
    rdc("pa_data in", gpp_pkg::IDX_PA_DATA, 32'h0000003C);
    chk("pa_af_in in", {24'h0, pa_af_in}, 32'h0000003C);
    // peripheral takes the low nibble
    pa_af_oe <= 8'h0F;
    pa_af_out <= 8'h05;
    cyc(4);
    chk("pa_oe af", {24'h0, pa_oe}, 32'h0000000F);
    chk("pa_out af", {28'h0, pa_out[3:0]}, 32'h00000005);
    rdc("pa_data af", gpp_pkg::IDX_PA_DATA, 32'h00000035);
    pa_af_oe <= 8'h00;
    // port b pin 0 as pull-up interrupt input, falling edge, masked first
    imask <= 1'b1;
    wr(gpp_pkg::IDX_PB_OPT, 8'h01);
    cyc(4);
    chk("pb_pull", {25'h0, pb_pull}, 32'h00000001);
    ext_en <= 15'h0100;
    ext_val <= 15'h0000;
    cyc(6);
    chk("pb_irq masked", {31'h0, pb_irq}, 32'h00000000);
    chk("wake masked", {31'h0, wake}, 32'h00000000);
    imask <= 1'b0;
    cyc(2);
    chk("pb_irq", {31'h0, pb_irq}, 32'h00000001);
    chk("wake", {31'h0, wake}, 32'h00000001);
    chk("pa_irq", {31'h0, pa_irq}, 32'h00000000);
    // both vectors fetched: the port b request must drop
    {pa_ack, pb_ack} <= 2'b11;
    cyc(1);
    {pa_ack, pb_ack} <= 2'b00;
    cyc(2);
    chk("pb_irq ack", {31'h0, pb_irq}, 32'h00000000);
    // second edge, cleared by a sensitivity write
    ext_en <= 15'h0000;
    cyc(4);
    ext_en <= 15'h0100;
    cyc(6);
    chk("pb_irq again", {31'h0, pb_irq}, 32'h00000001);
    rdc("ei_pend", gpp_pkg::IDX_EI_PEND, 32'h00000002);
    // switching port b to rising edges must drop the pending request
    wr(gpp_pkg::IDX_EI_CTRL, 8'h02);
    cyc(2);
    chk("pb_irq ctrl", {31'h0, pb_irq}, 32'h00000000);
    rdc("ei_ctrl", gpp_pkg::IDX_EI_CTRL, 32'h00000002);
    rdc("ei_pend clr", gpp_pkg::IDX_EI_PEND, 32'h00000000);
    // floating input: a toggling pad raises nothing
    wr(gpp_pkg::IDX_PB_OPT, 8'h00);
    ext_en <= 15'h0000;
    cyc(8);
    chk("pb_irq float", {31'h0, pb_irq}, 32'h00000000);
    // port b push-pull on all seven pins
    wr(gpp_pkg::IDX_PB_DIR, 8'h7F);
    wr(gpp_pkg::IDX_PB_OPT, 8'h7F);
    wr(gpp_pkg::IDX_PB_DATA, 8'h55);
    cyc(2);
    chk("pb_oe", {25'h0, pb_oe}, 32'h0000007F);
    chk("pb_out", {25'h0, pb_out}, 32'h00000055);
    chk("pb_af_in out", {25'h0, pb_af_in}, 32'h00000055);
    // peripheral takes pin 2 of port b and drives it low
    pb_af_oe <= 7'h04;
    pb_af_out <= 7'h00;
    cyc(4);
    chk("pb_out af", {25'h0, pb_out}, 32'h00000051);
    chk("pb_oe af", {25'h0, pb_oe}, 32'h0000007F);
    rdc("pb_data af", gpp_pkg::IDX_PB_DATA, 32'h00000051);
    print_verdict();
  end
endmodule : gpp_port_tb
`default_nettype wire
